//--- src/eif_regs.svh
// Register offsets, field positions and timing constants of the filter block
`ifndef EIF_REGS_SVH
`define EIF_REGS_SVH

// ****************************************************************
// Control register map
// ****************************************************************
`define EIF_CTRL_ADDR 16'h0037
`define EIF_CTRL_RESET 8'h00
`define EIF_CTRL_RW_MASK 8'hce
`define EIF_BIT_EXT1_NC 7
`define EIF_BIT_EXT0_PIN 6
`define EIF_BIT_EXT3_ES 3
`define EIF_BIT_EXT2_ES 2
`define EIF_BIT_EXT1_ES 1

// ****************************************************************
// Source indexes of the latch vector and of the accept code
// ****************************************************************
`define EIF_SRC_EXT0 3'h0
`define EIF_SRC_EXT1 3'h1
`define EIF_SRC_EXT2 3'h2
`define EIF_SRC_EXT3 3'h3
`define EIF_SRC_EXT5 3'h4
`define EIF_NUM_SRC 5

// ****************************************************************
// Trapped fetch areas
// ****************************************************************
`define EIF_SFR_FIRST 16'h0000
`define EIF_SFR_LAST 16'h003f
`define EIF_RAM_FIRST 16'h0040
`define EIF_RAM_LAST 16'h083f
`define EIF_DBR_FIRST 16'h0f80
`define EIF_DBR_LAST 16'h0fff

// ****************************************************************
// Filter times, in high-frequency clock periods, and their counts
// ****************************************************************
`define EIF_CLK_PERIOD_NS 40
`define EIF_FC_PERIOD_NS 40
`define EIF_T_REJ_SHORT_FC 2
`define EIF_T_REJ_MID_FC 7
`define EIF_T_REJ_EXT1_FAST_FC 15
`define EIF_T_REJ_EXT1_SLOW_FC 63
`define EIF_CYC(t) ((t * `EIF_FC_PERIOD_NS + `EIF_CLK_PERIOD_NS - 1) \
  / `EIF_CLK_PERIOD_NS)
`define EIF_CNT_SHORT 6'(`EIF_CYC(`EIF_T_REJ_SHORT_FC))
`define EIF_CNT_MID 6'(`EIF_CYC(`EIF_T_REJ_MID_FC))
`define EIF_CNT_EXT1_FAST 6'(`EIF_CYC(`EIF_T_REJ_EXT1_FAST_FC))
`define EIF_CNT_EXT1_SLOW 6'(`EIF_CYC(`EIF_T_REJ_EXT1_SLOW_FC))
// Low-clock ticks a level must hold in slow or sleep mode
`define EIF_CNT_SLOW_TICKS 6'h02
`define EIF_CNT_ONE 6'h01
`define EIF_CNT_ZERO 6'h00

`endif

//--- src/eif_pkg.sv
// Types shared by the external interrupt filter block
package eif_pkg;

  // ****************************************************************
  // Clock mode that times the noise filters
  // ****************************************************************
  typedef enum logic {
    EIF_MODE_FAST,
    EIF_MODE_SLOW
  } eif_mode_type;

endpackage : eif_pkg

//--- src/eif_filter.sv
// One noise rejection filter with synchroniser and edge detector
`timescale 1ns/1ps
`include "eif_regs.svh"

module eif_filter (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pin_raw,
  input wire logic [5:0] fast_thresh,
  input wire eif_pkg::eif_mode_type mode,
  input wire logic fs_tick,
  output logic filt_level,
  output logic rise_pulse,
  output logic fall_pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic sync1_q; // First stage, read only by the second
  logic sync2_q;
  logic filt_q, filt_d; // Accepted level
  logic [5:0] cnt_q, cnt_d; // Cycles or ticks the new level has held
  logic rise_q, rise_d;
  logic fall_q, fall_d;
  logic step; // Counter advances this cycle
  logic [5:0] thresh;

  // Synchronise the pin before anything looks at it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Count how long the synchronised level differs from the accepted one
  always_comb begin
    step = (mode == eif_pkg::EIF_MODE_SLOW) ? fs_tick : 1'b1;
    // Slow mode counts low-clock ticks, so the window is in fs units
    thresh = (mode == eif_pkg::EIF_MODE_SLOW) ? `EIF_CNT_SLOW_TICKS
                                              : fast_thresh;
    filt_d = filt_q;
    cnt_d = cnt_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (sync2_q == filt_q) begin
      // Short pulse ended before the window ran out: drop it
      cnt_d = `EIF_CNT_ZERO;
    end else if (step) begin
      if (cnt_q + `EIF_CNT_ONE >= thresh) begin
        // Held long enough: take the new level
        filt_d = sync2_q;
        cnt_d = `EIF_CNT_ZERO;
        rise_d = sync2_q;
        fall_d = ~sync2_q;
      end else begin
        cnt_d = cnt_q + `EIF_CNT_ONE;
      end
    end
  end

  // Register the filter state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // Idle level high so a pulled-up pin gives no edge at start
      filt_q <= 1'b1;
      cnt_q <= `EIF_CNT_ZERO;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      filt_q <= filt_d;
      cnt_q <= cnt_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign filt_level = filt_q;
  assign rise_pulse = rise_q;
  assign fall_pulse = fall_q;

endmodule : eif_filter

//--- src/eif_top.sv
// External interrupt filters, latches, control register and address trap
`timescale 1ns/1ps
`include "eif_regs.svh"

module eif_top (
  input wire logic sys_clk,
  input wire logic reset,
  // Register access
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // External pins
  input wire logic ext_irq_0,
  input wire logic ext_irq_1,
  input wire logic ext_irq_2,
  input wire logic ext_irq_3,
  input wire logic ext_irq_5,
  output logic port6_bit3,
  // Clock mode
  input wire logic slow_mode,
  input wire logic fs_tick,
  // Enables from the interrupt enable register
  input wire logic master_irq_enable,
  input wire logic enable_flag_4,
  input wire logic enable_flag_5,
  input wire logic enable_flag_7,
  input wire logic enable_flag_14,
  input wire logic enable_flag_15,
  input wire logic latch14_route_select,
  input wire logic latch15_route_select,
  // Acceptance by the CPU
  input wire logic irq_accept,
  input wire logic [2:0] irq_accept_sel,
  output logic [4:0] irq_latch,
  output logic [4:0] irq_request,
  output logic master_irq_clear,
  // Instruction fetch watch
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic trap_irq_select,
  output logic address_trap_irq,
  output logic trap_reset_out
);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [7:0] ctrl_q, ctrl_d; // ext_irq_control
  logic [7:0] rdata_q, rdata_d;
  logic ctrl_hit;

  // Decode the single register address
  always_comb begin
    if (bus_addr == `EIF_CTRL_ADDR) begin
      ctrl_hit = 1'b1;
    end else begin
      ctrl_hit = 1'b0;
    end
  end

  // Write stores only implemented bits; reads give zero elsewhere
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    if (bus_wr && ctrl_hit) begin
      ctrl_d = bus_wdata & `EIF_CTRL_RW_MASK;
    end
    if (bus_rd) begin
      rdata_d = ctrl_hit ? ctrl_q : 8'h00;
    end
  end

  // Register the control state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // Noise select, pin function and edge selects all clear
      ctrl_q <= `EIF_CTRL_RESET;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  // ****************************************************************
  // Field views
  // ****************************************************************
  logic ext1_filter_select;
  logic ext0_pin_function;
  logic ext1_edge_select;
  logic ext2_edge_select;
  logic ext3_edge_select;
  eif_pkg::eif_mode_type mode;

  assign ext1_filter_select = ctrl_q[`EIF_BIT_EXT1_NC];
  assign ext0_pin_function = ctrl_q[`EIF_BIT_EXT0_PIN];
  assign ext1_edge_select = ctrl_q[`EIF_BIT_EXT1_ES];
  assign ext2_edge_select = ctrl_q[`EIF_BIT_EXT2_ES];
  assign ext3_edge_select = ctrl_q[`EIF_BIT_EXT3_ES];
  assign mode = slow_mode ? eif_pkg::EIF_MODE_SLOW : eif_pkg::EIF_MODE_FAST;

  // ****************************************************************
  // Filter windows per source
  // ****************************************************************
  logic [5:0] thresh [`EIF_NUM_SRC];
  logic [4:0] pin_vec;
  logic [4:0] filt_vec;
  logic [4:0] rise_vec;
  logic [4:0] fall_vec;

  // Pick each window; the select bit feeds straight in, so a change
  // applies on the next clock, well inside the allowed settling time
  always_comb begin
    thresh[`EIF_SRC_EXT0] = `EIF_CNT_SHORT;
    thresh[`EIF_SRC_EXT5] = `EIF_CNT_SHORT;
    thresh[`EIF_SRC_EXT2] = `EIF_CNT_MID;
    thresh[`EIF_SRC_EXT3] = `EIF_CNT_MID;
    if (ext1_filter_select) begin
      thresh[`EIF_SRC_EXT1] = `EIF_CNT_EXT1_FAST;
    end else begin
      thresh[`EIF_SRC_EXT1] = `EIF_CNT_EXT1_SLOW;
    end
  end

  // The pins are sampled as seen, including levels this chip drives,
  // so output activity on a shared pin can raise a request
  assign pin_vec = {ext_irq_5, ext_irq_3, ext_irq_2, ext_irq_1,
                    ext_irq_0};

  // One filter per external input
  genvar gi;
  generate
    for (gi = 0; gi < `EIF_NUM_SRC; gi++) begin : g_filt
      eif_filter u_filt (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_raw(pin_vec[gi]),
        .fast_thresh(thresh[gi]),
        .mode(mode),
        .fs_tick(fs_tick),
        .filt_level(filt_vec[gi]),
        .rise_pulse(rise_vec[gi]),
        .fall_pulse(fall_vec[gi])
      );
    end
  endgenerate

  // The shared pin reads as a plain port while not in interrupt use
  logic port_q, port_d;

  always_comb begin
    port_d = ext0_pin_function ? 1'b1 : filt_vec[`EIF_SRC_EXT0];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port_q <= 1'b1;
    end else begin
      port_q <= port_d;
    end
  end

  assign port6_bit3 = port_q;

  // ****************************************************************
  // Edge choice and latches
  // ****************************************************************
  logic [4:0] edge_vec; // Active edge seen this cycle
  logic [4:0] latch_q, latch_d;
  logic [4:0] enable_vec;
  logic [4:0] accept_vec;
  logic clear_q, clear_d;

  // Select the active edge of each source
  always_comb begin
    // Fixed falling edge; port role blocks the latch
    edge_vec[`EIF_SRC_EXT0] = fall_vec[`EIF_SRC_EXT0] &
                              ext0_pin_function;
    edge_vec[`EIF_SRC_EXT5] = fall_vec[`EIF_SRC_EXT5];
    edge_vec[`EIF_SRC_EXT1] = ext1_edge_select ? fall_vec[`EIF_SRC_EXT1]
                                               : rise_vec[`EIF_SRC_EXT1];
    edge_vec[`EIF_SRC_EXT2] = ext2_edge_select ? fall_vec[`EIF_SRC_EXT2]
                                               : rise_vec[`EIF_SRC_EXT2];
    edge_vec[`EIF_SRC_EXT3] = ext3_edge_select ? fall_vec[`EIF_SRC_EXT3]
                                               : rise_vec[`EIF_SRC_EXT3];
    // Edge selects above: 0 rising, 1 falling
  end

  // Per-source enable terms
  always_comb begin
    enable_vec[`EIF_SRC_EXT0] = enable_flag_4 & ext0_pin_function;
    enable_vec[`EIF_SRC_EXT1] = enable_flag_5;
    enable_vec[`EIF_SRC_EXT2] = enable_flag_7;
    enable_vec[`EIF_SRC_EXT3] = enable_flag_14 & ~latch14_route_select;
    enable_vec[`EIF_SRC_EXT5] = enable_flag_15 & ~latch15_route_select;
  end

  assign irq_request = latch_q & enable_vec &
                       {`EIF_NUM_SRC{master_irq_enable}};

  // Acceptance clears one latch; a new edge in that cycle still sets it
  always_comb begin
    accept_vec = 5'h00;
    clear_d = 1'b0;
    if (irq_accept && (irq_accept_sel < 3'(`EIF_NUM_SRC))) begin
      if (irq_request[irq_accept_sel]) begin
        accept_vec[irq_accept_sel] = 1'b1;
        clear_d = 1'b1;
      end
    end
    // The edge pulse comes in the same cycle as the filter settles, which keeps
    // latch delay to a few clocks, well under the allowed bound
    latch_d = (latch_q & ~accept_vec) | edge_vec;
  end

  // Register the latches
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_q <= 5'h00;
      clear_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      clear_q <= clear_d;
    end
  end

  assign irq_latch = latch_q;
  assign master_irq_clear = clear_q;

  // Software must mask these sources while it changes clock mode or
  // rewrites the control register; glitches then are not suppressed
  // here

  // ****************************************************************
  // Address trap
  // ****************************************************************
  logic trapped; // Fetch address falls in a trapped area
  logic trap_irq_q, trap_irq_d;
  logic trap_rst_q, trap_rst_d;

  // Decode the trapped areas
  always_comb begin
    if (fetch_addr <= `EIF_SFR_LAST) begin
      trapped = 1'b1;
    end else if ((fetch_addr >= `EIF_RAM_FIRST) &&
                 (fetch_addr <= `EIF_RAM_LAST)) begin
      trapped = 1'b1;
    end else if ((fetch_addr >= `EIF_DBR_FIRST) &&
                 (fetch_addr <= `EIF_DBR_LAST)) begin
      trapped = 1'b1;
    end else begin
      trapped = 1'b0;
    end
  end

  // Route a trapped fetch by the watchdog setting; master enable and a
  // running non-maskable service are deliberately not consulted
  always_comb begin
    trap_irq_d = fetch_valid & trapped & trap_irq_select;
    trap_rst_d = fetch_valid & trapped & ~trap_irq_select;
  end

  // Register the trap outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trap_irq_q <= 1'b0;
      trap_rst_q <= 1'b0;
    end else begin
      trap_irq_q <= trap_irq_d;
      trap_rst_q <= trap_rst_d;
    end
  end

  assign address_trap_irq = trap_irq_q;
  assign trap_reset_out = trap_rst_q;

endmodule : eif_top

//--- verif/eif_pin_src.sv
// Model of the signal sources that drive the five interrupt pins
`timescale 1ns/1ps
module eif_pin_src (
  input wire logic sys_clk,
  output logic [4:0] pins
);
  // Pins idle high, the inactive level of every source
  initial pins = 5'h1f;

  // Changes one pin just after a rising edge, then holds it
  task automatic set_pin(input int idx, input logic val);
    @(posedge sys_clk);
    pins[idx] <= val;
  endtask : set_pin
endmodule : eif_pin_src

//--- verif/eif_top_monitor.sv
// Port assertions of the external interrupt filter block
`timescale 1ns/1ps
`include "eif_regs.svh"
module eif_top_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ext_irq_2,
  input wire logic slow_mode,
  input wire logic master_irq_enable,
  input wire logic enable_flag_5,
  input wire logic enable_flag_7,
  input wire logic enable_flag_14,
  input wire logic enable_flag_15,
  input wire logic latch14_route_select,
  input wire logic latch15_route_select,
  input wire logic irq_accept,
  input wire logic [2:0] irq_accept_sel,
  input wire logic [4:0] irq_latch,
  input wire logic [4:0] irq_request,
  input wire logic master_irq_clear,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic trap_irq_select,
  input wire logic address_trap_irq,
  input wire logic trap_reset_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic hit; // Fetch lands in a trapped area
  logic acc_ok; // Accept of a source that is really requesting
  logic m; // Master enable, short name
  logic prev2_q, prev2_d; // Pin 2 level one cycle ago
  logic [4:0] quiet2_q, quiet2_d; // Cycles since pin 2 last moved
  assign m = master_irq_enable;
  assign hit = fetch_valid && (fetch_addr <= `EIF_RAM_LAST ||
    (fetch_addr >= `EIF_DBR_FIRST && fetch_addr <= `EIF_DBR_LAST));
  assign acc_ok = irq_accept && irq_accept_sel <= 3'h4 &&
    irq_request[irq_accept_sel];

  // Saturating quiet counter, so a latch with no pin cause is caught
  always_comb begin
    prev2_d = ext_irq_2;
    quiet2_d = quiet2_q + 5'(quiet2_q != 5'h1f);
    if (reset || ext_irq_2 != prev2_q) begin
      quiet2_d = 5'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    prev2_q <= prev2_d;
    quiet2_q <= quiet2_d;
  end

  chk_trap_irq_out: assert property (hit && trap_irq_select |=>
    address_trap_irq && !trap_reset_out) else $error("trap irq missing");
  chk_trap_rst_out: assert property (hit && !trap_irq_select |=>
    trap_reset_out && !address_trap_irq) else $error("trap reset missing");
  chk_trap_quiet: assert property (!hit |=>
    !address_trap_irq && !trap_reset_out) else $error("spurious trap");
  chk_request_gate: assert property (irq_request[4:1] ==
    {irq_latch[4] & m & enable_flag_15 & !latch15_route_select,
    irq_latch[3] & m & enable_flag_14 & !latch14_route_select,
    irq_latch[2] & m & enable_flag_7, irq_latch[1] & m & enable_flag_5})
    else $error("request gating wrong");
  chk_accept_clear: assert property (acc_ok |=> master_irq_clear)
    else $error("master clear missing");
  chk_clear_cause: assert property (master_irq_clear |->
    $past(acc_ok)) else $error("master clear without accept");
  chk_latch_hold: assert property (|(~irq_latch & $past(irq_latch))
    |-> $past(irq_accept)) else $error("latch lost without accept");
  chk_ext2_cause: assert property ($rose(irq_latch[2]) && !slow_mode
    |-> quiet2_q < 5'h10) else $error("latch 2 set without pin edge");
endmodule : eif_top_monitor

bind eif_top eif_top_monitor u_eif_top_monitor (.sys_clk, .reset,
  .ext_irq_2, .slow_mode, .master_irq_enable, .enable_flag_5,
  .enable_flag_7, .enable_flag_14, .enable_flag_15, .latch14_route_select,
  .latch15_route_select, .irq_accept, .irq_accept_sel, .irq_latch,
  .irq_request, .master_irq_clear, .fetch_valid, .fetch_addr,
  .trap_irq_select, .address_trap_irq, .trap_reset_out);

//--- verif/external_interrupt_filter_tb.sv
// Self-checking bench of the external interrupt filter block
`timescale 1ns/1ps
module external_interrupt_filter_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata, d;
  logic [4:0] pins, irq_latch, irq_request;
  logic port6_bit3, trap_irq, trap_rst, hit;
  logic mclr; // Master enable clear pulse from the block
  logic slow_mode = 1'b0;
  logic fs_tick = 1'b0;
  logic [2:0] fdiv = 3'h0; // Low clock divider
  logic [5:0] en = 6'h3f; // Master enable, then the five source enables
  logic [1:0] rt = 2'h0; // Latch route selects
  logic irq_accept = 1'b0;
  logic [2:0] sel = 3'h0;
  logic fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'h1000;
  logic [15:0] a;
  logic tsel = 1'b0;
  int mismatches = 0;
  int n_tests = 0;
  int ctrl_m = 0; // Model of the control register
  int lat_m[5] = '{default: 0}; // Model of the latches
  int slow_m = 0; // Model knows the filters run on the low clock

  always #20 sys_clk = ~sys_clk;

  // Low-frequency tick once every 8 system clocks
  always @(posedge sys_clk) begin
    fdiv <= fdiv + 3'h1;
    fs_tick <= (fdiv == 3'h7);
  end

  eif_pin_src u_eif_pin_src (.sys_clk(sys_clk), .pins(pins));

  eif_top u_eif_top (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .ext_irq_0(pins[0]), .ext_irq_1(pins[1]),
    .ext_irq_2(pins[2]), .ext_irq_3(pins[3]), .ext_irq_5(pins[4]),
    .port6_bit3(port6_bit3), .slow_mode(slow_mode), .fs_tick(fs_tick),
    .master_irq_enable(en[0]), .enable_flag_4(en[1]),
    .enable_flag_5(en[2]), .enable_flag_7(en[3]), .enable_flag_14(en[4]),
    .enable_flag_15(en[5]), .latch14_route_select(rt[0]),
    .latch15_route_select(rt[1]), .irq_accept(irq_accept),
    .irq_accept_sel(sel), .irq_latch(irq_latch), .irq_request(irq_request),
    .master_irq_clear(mclr), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .trap_irq_select(tsel), .address_trap_irq(trap_irq),
    .trap_reset_out(trap_rst));

  // ****************************************************************
  // Model, bus tasks and compares
  // ****************************************************************
  // Shortest accepted pulse in cycles
  function automatic int thr(input int i);
    if (slow_m != 0) return 28;
    if (i == 1) return ctrl_m[7] ? 15 : 63;
    return (i == 2 || i == 3) ? 7 : 2;
  endfunction : thr

  function automatic logic req_m(input int i);
    logic gate;
    gate = (i != 0 || ctrl_m[6]) && !(i == 3 && rt[0]) && !(i == 4 && rt[1]);
    return lat_m[i] != 0 && en[0] && en[i + 1] && gate;
  endfunction : req_m

  // Wait for edges, then let their updates land
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic chk_bit(input logic got, input logic exp, input string s);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %0t %s", $time, s);
      mismatches++;
    end
  endtask : chk_bit

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %0t reg read %h", $time, got);
      mismatches++;
    end
  endtask : chk_reg

  task automatic chk_lat();
    for (int i = 0; i < 5; i++) begin
      chk_bit(irq_latch[i], lat_m[i] != 0, "latch");
      chk_bit(irq_request[i], req_m(i), "request");
    end
  endtask : chk_lat

  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    @(posedge sys_clk);
    en[0] <= 1'b0; // Masked around a control write
    bus_addr <= ad;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    en[0] <= 1'b1;
    if (ad == 16'h0037) ctrl_m = v & 8'hce;
  endtask : wr

  task automatic rd(input logic [15:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask : rd

  // Low pulse of len cycles on one pin, then time to settle
  task automatic pulse(input int i, input int len);
    u_eif_pin_src.set_pin(i, 1'b0);
    repeat (len - 1) @(posedge sys_clk);
    u_eif_pin_src.set_pin(i, 1'b1);
    settle(80);
    if (len >= thr(i) && (i != 0 || ctrl_m[6])) lat_m[i] = 1;
  endtask : pulse

  // Accepts each source in turn; only requesting ones clear
  task automatic clr();
    logic want;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      irq_accept <= 1'b1;
      sel <= 3'(i);
      @(posedge sys_clk);
      irq_accept <= 1'b0;
      want = req_m(i);
      if (want) lat_m[i] = 0;
      // Clear pulse stands for the cycle after an effective accept
      #1;
      chk_bit(mclr, want, "master clear");
    end
    settle(1);
  endtask : clr

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h82e1296b));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    settle(2);
    rd(16'h0037, d);
    chk_reg(d, 8'h00);
    chk_bit(port6_bit3, 1'b1, "port idle");
    wr(16'h0037, 8'($urandom));
    rd(16'h0037, d);
    chk_reg(d, 8'(ctrl_m));
    wr(16'h0036, 8'hff);
    rd(16'h0036, d);
    chk_reg(d, 8'h00);
    $display("register test done");
    // Port role: pin 0 shows on the port bit and never latches
    wr(16'h0037, 8'h00);
    u_eif_pin_src.set_pin(0, 1'b0);
    settle(10);
    chk_bit(port6_bit3, 1'b0, "port level");
    pulse(0, 20);
    chk_lat();
    $display("port role test done");
    for (int k = 0; k < 2; k++) begin
      wr(16'h0037, k ? 8'hc0 : 8'h40);
      settle(2);
      chk_bit(port6_bit3, 1'b1, "port in irq role");
      for (int i = 0; i < 5; i++) begin
        pulse(i, thr(i) - 1);
        chk_lat();
        pulse(i, thr(i));
        chk_lat();
        clr();
        chk_lat();
      end
    end
    $display("filter test done");
    for (int s = 0; s < 2; s++) begin
      wr(16'h0037, s ? 8'h4e : 8'h40);
      for (int i = 1; i < 4; i++) begin
        u_eif_pin_src.set_pin(i, 1'b0);
        settle(80);
        lat_m[i] = s;
        chk_lat();
        u_eif_pin_src.set_pin(i, 1'b1);
        settle(80);
        lat_m[i] = 1;
        chk_lat();
        clr();
      end
    end
    u_eif_pin_src.set_pin(2, 1'b0);
    settle(6);
    chk_bit(irq_latch[2], 1'b0, "latch early");
    settle(6);
    chk_bit(irq_latch[2], 1'b1, "latch late");
    lat_m[2] = 1;
    pulse(3, 20);
    pulse(0, 20);
    $display("edge test done");
    for (int j = 0; j < 8; j++) begin
      @(posedge sys_clk);
      en <= 6'($urandom);
      rt <= 2'($urandom);
      settle(1);
      chk_lat();
    end
    clr();
    chk_lat();
    en <= 6'h3f;
    rt <= 2'h0;
    clr();
    $display("gating test done");
    slow_mode <= 1'b1;
    slow_m = 1;
    for (int i = 0; i < 5; i++) begin
      pulse(i, 7);
      chk_lat();
      pulse(i, 28);
      chk_lat();
      clr();
    end
    slow_mode <= 1'b0;
    slow_m = 0;
    $display("slow test done");
    // Reset in mid-run must drop a pending latch and the control bits
    pulse(2, 20);
    chk_lat();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    ctrl_m = 0;
    lat_m = '{default: 0};
    settle(2);
    chk_lat();
    chk_bit(port6_bit3, 1'b1, "port after reset");
    rd(16'h0037, d);
    chk_reg(d, 8'h00);
    $display("reset test done");
    en[0] <= 1'b0;
    for (int j = 0; j < 16; j++) begin
      a = (j < 2) ? 16'h0040 : 16'($urandom) & 16'h1fff;
      hit = a <= 16'h083f || (a >= 16'h0f80 && a <= 16'h0fff);
      @(posedge sys_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      tsel <= j[0];
      settle(1);
      chk_bit(trap_irq, hit && j[0], "trap irq");
      chk_bit(trap_rst, hit && !j[0], "trap reset");
    end
    fetch_valid <= 1'b0;
    $display("trap test done");
    give_verdict();
  end
endmodule : external_interrupt_filter_tb
